// ==== rtl/ddc_pkg.sv ====
// Shared constants for the dual converter serial command port.
// Assumes both ends are compiled against this package.
package ddc_pkg;
  localparam int unsigned FRAME_BITS      = 24;
  localparam int unsigned CNT_W           = 5;
  localparam logic [4:0]  LAST_BIT_CNT    = 5'h18;
  localparam int unsigned CMD_MSB         = 21;
  localparam int unsigned CMD_LSB         = 19;
  localparam int unsigned ADDR_MSB        = 18;
  localparam int unsigned ADDR_LSB        = 16;
  localparam int unsigned DATA_MSB        = 15;
  localparam int unsigned PD_HI_BIT       = 5;
  localparam int unsigned PD_LO_BIT       = 4;
  localparam int unsigned SEL_B_BIT       = 1;
  localparam int unsigned SEL_A_BIT       = 0;
  localparam int unsigned RST_DEPTH_BIT   = 0;
  localparam logic [2:0]  CMD_WR_IN       = 3'h0;
  localparam logic [2:0]  CMD_UPD         = 3'h1;
  localparam logic [2:0]  CMD_WR_UPD_ALL  = 3'h2;
  localparam logic [2:0]  CMD_WR_UPD      = 3'h3;
  localparam logic [2:0]  CMD_POWER       = 3'h4;
  localparam logic [2:0]  CMD_RESET       = 3'h5;
  localparam logic [2:0]  CMD_LMASK       = 3'h6;
  localparam logic [2:0]  ADDR_A          = 3'h0;
  localparam logic [2:0]  ADDR_B          = 3'h1;
  localparam logic [2:0]  ADDR_ALL        = 3'h7;
  localparam logic [1:0]  PD_NORMAL       = 2'h0;
  localparam logic [15:0] ZERO_CODE       = 16'h0000;
  localparam logic [15:0] MID_CODE        = 16'h8000;
  // Sys clock, link timing and host register map
  localparam int unsigned SYS_CLK_MHZ     = 25;
  localparam int unsigned SYS_PERIOD_NS   = 40;
  localparam int unsigned PWRUP_US        = 4;
  localparam int unsigned PWRUP_CYC       = PWRUP_US * SYS_CLK_MHZ;
  localparam int unsigned SYNC_HIGH_NS    = 15;
  localparam int unsigned SYNC_HIGH_CYC   = (SYNC_HIGH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned HOST_DIV        = 4;
  localparam int unsigned ADDR_CTRL       = 0;
  localparam int unsigned ADDR_DATA       = 4;
  localparam int unsigned ADDR_STAT       = 8;
  localparam logic [31:0] UNMAPPED_RD     = 32'h0000_0000;
endpackage

// ==== rtl/ddc_link_if.sv ====
// Three-wire link between host and converter port.
// Assumes the bench drives one shared sys_clk and nrst to both ends.
`timescale 1ns/1ps
interface ddc_link_if;
  logic frame_sel_n;
  logic sclk;
  logic sdin;
  modport host   (output frame_sel_n, output sclk, output sdin);
  modport device (input frame_sel_n, input sclk, input sdin);
endinterface

// ==== rtl/ddc_device.sv ====
// Converter-side serial command port: shift register, decode, register banks.
// Assumes link pins are asynchronous to sys_clk and far slower than it.
`timescale 1ns/1ps
// Functional notes
// - Frame select falling edge starts frame
// - Shift data in on falling clock edges
// - Host keeps serial clock at most 50MHz
// - 24th edge captures bit and executes
// - Frame select high 15ns between frames
// - Host may park frame select low
// - Frame: 2 ignored, cmd, addr, data
// - Decode seven command codes; 111 does nothing
// - Address A, B, or both
// - Early frame select rise discards frame
// - Outputs zero or midscale after power-on
// - Ignore load strobe during power-on reset
// - Reset command, DB0 selects depth
// - Power mode from DB5:DB4
// - Mode applies to selected channels only
// - Power-up output source follows strobe
// - Converter registers hold while powered down, except a reset command clears them
// - Power-up pending flag for 4us
// - Low strobe makes converter follow input
// - Command 110 loads per-channel load mask
// - Strobe update only if input written since
module ddc_device
  import ddc_pkg::*;
#(
  parameter bit MIDSCALE = 1'b0
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Serial link
  ddc_link_if.device       link,
  // Load strobe pin, async
  input  wire logic        load_strobe_n,
  // Converter state
  output logic [15:0]      dac_a_q,
  output logic [15:0]      dac_b_q,
  output logic [1:0]       pd_a_q,
  output logic [1:0]       pd_b_q,
  output logic [1:0]       pwrup_pend_q,
  output logic             frame_done_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0]       fs_s_q, ck_s_q, di_s_q, ld_s_q;
  logic             fs_d1_q, ck_d1_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fs_s_q  <= 2'h3;
      ck_s_q  <= 2'h0;
      di_s_q  <= 2'h0;
      ld_s_q  <= 2'h3;
      fs_d1_q <= 1'b1;
      ck_d1_q <= 1'b0;
    end else begin
      fs_s_q  <= {fs_s_q[0], link.frame_sel_n};
      ck_s_q  <= {ck_s_q[0], link.sclk};
      di_s_q  <= {di_s_q[0], link.sdin};
      ld_s_q  <= {ld_s_q[0], load_strobe_n};
      fs_d1_q <= fs_s_q[1];
      ck_d1_q <= ck_s_q[1];
    end
  end

  // Edge detects on the second stage only
  wire fs_low  = !fs_s_q[1];
  wire fs_fall = fs_d1_q && !fs_s_q[1];
  wire ck_fall = ck_d1_q && !ck_s_q[1];
  wire ld_low  = !ld_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame shift and bit count
  logic [23:0]      shift_q;
  logic [CNT_W-1:0] cnt_q;
  logic             armed_q;
  wire              take_bit = fs_low && armed_q && ck_fall && (cnt_q != LAST_BIT_CNT);
  wire [23:0]       shift_d  = {shift_q[22:0], di_s_q[1]};
  wire              exec     = take_bit && (cnt_q == LAST_BIT_CNT - 5'h1);

  // Frame select rise clears partial frame; fall re-arms
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= '0;
      cnt_q   <= '0;
      armed_q <= 1'b0;
    end else if (!fs_low) begin
      shift_q <= '0;
      cnt_q   <= '0;
      armed_q <= 1'b0;
    end else if (fs_fall) begin
      shift_q <= '0;
      cnt_q   <= '0;
      armed_q <= 1'b1;
    end else if (take_bit) begin
      shift_q <= shift_d;
      cnt_q   <= cnt_q + 5'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode of the completed word
  wire [2:0]  cmd    = shift_d[CMD_MSB:CMD_LSB];
  wire [2:0]  addr   = shift_d[ADDR_MSB:ADDR_LSB];
  wire [15:0] data   = shift_d[DATA_MSB:0];
  wire        hit_a  = (addr == ADDR_A) || (addr == ADDR_ALL);
  wire        hit_b  = (addr == ADDR_B) || (addr == ADDR_ALL);
  wire [1:0]  hit    = {hit_b, hit_a};
  wire [1:0]  pdmode = {shift_d[PD_HI_BIT], shift_d[PD_LO_BIT]};
  wire [1:0]  psel   = {shift_d[SEL_B_BIT], shift_d[SEL_A_BIT]};
  wire        wr_in  = exec && (cmd == CMD_WR_IN || cmd == CMD_WR_UPD_ALL || cmd == CMD_WR_UPD);
  wire        upd_c  = exec && (cmd == CMD_UPD || cmd == CMD_WR_UPD);
  wire        addr_ok = hit_a || hit_b;
  wire        upd_al = exec && (cmd == CMD_WR_UPD_ALL) && addr_ok;
  wire        pwr    = exec && (cmd == CMD_POWER);
  wire        rst_c  = exec && (cmd == CMD_RESET);
  wire        rst_f  = rst_c && shift_d[RST_DEPTH_BIT];
  wire        lmsk   = exec && (cmd == CMD_LMASK);
  wire [15:0] init_code = MIDSCALE ? MID_CODE : ZERO_CODE;
  // Only a frame that acts ends the power-on code; reserved frames leave it
  wire        act    = ((wr_in || upd_c) && addr_ok) || upd_al || pwr || rst_c || lmsk;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel registers
  logic [15:0] in_q   [2];
  logic [15:0] dac_q  [2];
  logic [1:0]  pd_q   [2];
  logic [1:0]  lmask_q;
  logic        dirty_q [2];
  logic [6:0]  pend_cnt_q [2];

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      // Load strobe is ignored until reset released; sync stages preset high
      wire pwr_sel  = pwr && psel[ch];
      wire pwr_up   = pwr_sel && (pdmode == PD_NORMAL) && (pd_q[ch] != PD_NORMAL);
      wire in_wr    = wr_in && hit[ch];
      wire [15:0] in_n = in_wr ? data : in_q[ch];
      wire dirty_n  = in_wr || dirty_q[ch];
      wire sw_upd   = (upd_c && hit[ch]) || upd_al || (exec && lmask_q[ch] && in_wr);
      wire hw_upd   = ld_low && dirty_n;
      wire up_ld    = pwr_up && ld_low;
      wire do_upd   = (sw_upd || hw_upd || up_ld) && (pd_q[ch] == PD_NORMAL || up_ld);
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          in_q[ch]       <= ZERO_CODE;
          dac_q[ch]      <= ZERO_CODE;
          pd_q[ch]       <= PD_NORMAL;
          dirty_q[ch]    <= 1'b0;
          pend_cnt_q[ch] <= '0;
        end else if (rst_c) begin
          in_q[ch]    <= ZERO_CODE;
          dac_q[ch]   <= ZERO_CODE;
          dirty_q[ch] <= 1'b0;
          if (rst_f) begin
            pd_q[ch] <= PD_NORMAL;
          end
        end else begin
          in_q[ch] <= in_n;
          if (do_upd) begin
            dac_q[ch]   <= in_n;
            dirty_q[ch] <= 1'b0;
          end else begin
            dirty_q[ch] <= dirty_n;
          end
          if (pwr_sel) begin
            pd_q[ch] <= pdmode;
          end
          if (pwr_up) begin
            pend_cnt_q[ch] <= 7'(PWRUP_CYC);
          end else if (pend_cnt_q[ch] != 7'h0) begin
            pend_cnt_q[ch] <= pend_cnt_q[ch] - 7'h1;
          end
        end
      end
    end
  endgenerate

  // Load mask register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lmask_q <= 2'h0;
    end else if (rst_f) begin
      lmask_q <= 2'h0;
    end else if (lmsk) begin
      lmask_q <= psel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; the power-on code (zero, or midscale with MIDSCALE set) shows until the first frame that acts
  logic seen_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seen_q       <= 1'b0;
      dac_a_q      <= ZERO_CODE;
      dac_b_q      <= ZERO_CODE;
      pd_a_q       <= PD_NORMAL;
      pd_b_q       <= PD_NORMAL;
      pwrup_pend_q <= 2'h0;
      frame_done_q <= 1'b0;
    end else begin
      seen_q       <= seen_q || act;
      dac_a_q      <= seen_q ? dac_q[0] : init_code;
      dac_b_q      <= seen_q ? dac_q[1] : init_code;
      pd_a_q       <= pd_q[0];
      pd_b_q       <= pd_q[1];
      pwrup_pend_q <= {pend_cnt_q[1] != 7'h0, pend_cnt_q[0] != 7'h0};
      frame_done_q <= exec;
    end
  end
endmodule

// ==== rtl/ddc_host.sv ====
// Host end: AHB-Lite slave registers and serial frame master.
// Assumes one AHB master; link pins sampled by the device end.
`timescale 1ns/1ps
module ddc_host
  import ddc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial link
  ddc_link_if.host         link
);

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture
  logic        wr_q;
  logic [31:0] wa_q;
  logic [23:0] word_q;
  logic        busy_q;
  wire         ap = hsel && hready && htrans[1];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      wa_q <= 32'h0;
    end else begin
      wr_q <= ap && hwrite;
      wa_q <= haddr;
    end
  end

  // Read mux, zero-wait answer
  // Full address compare, so aliases above the map never start a frame
  wire [31:0] rd_mux = (haddr == 32'(ADDR_DATA)) ? {8'h00, word_q} :
                       (haddr == 32'(ADDR_STAT)) ? {31'h0, busy_q} : UNMAPPED_RD;
  wire        start  = wr_q && (wa_q == 32'(ADDR_CTRL)) && hwdata[0] && !busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial master; clock from divider, MSB first
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_SHIFT = 2'b01, HS_GAP = 2'b11} ddc_hst_t;
  ddc_hst_t   st_q;
  logic [1:0] div_q;
  logic [4:0] bits_q;
  logic [23:0] sh_q;
  wire        tick = (div_q == 2'(HOST_DIV - 1));
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= HS_IDLE;
      div_q  <= 2'h0;
      bits_q <= 5'h0;
      sh_q   <= 24'h0;
      word_q <= 24'h0;
      busy_q <= 1'b0;
      hrdata <= 32'h0;
      link.frame_sel_n <= 1'b1;
      link.sclk        <= 1'b0;
      link.sdin        <= 1'b0;
    end else begin
      hrdata <= rd_mux;
      if (wr_q && wa_q == 32'(ADDR_DATA) && !busy_q) begin
        word_q <= hwdata[23:0];
      end
      div_q <= tick ? 2'h0 : div_q + 2'h1;
      unique case (st_q)
        HS_IDLE: begin
          if (start) begin
            busy_q           <= 1'b1;
            st_q             <= HS_SHIFT;
            sh_q             <= word_q;
            bits_q           <= 5'h0;
            div_q            <= 2'h0;
            link.frame_sel_n <= 1'b0;
            link.sdin        <= word_q[FRAME_BITS-1];
          end
        end
        HS_SHIFT: begin
          // Clock rises at mid-count, falls at tick, 160ns period keeps under 50MHz
          // Data moves on the rise, so it is settled when the far end samples the fall
          if (div_q == 2'h1) begin
            link.sclk <= 1'b1;
            link.sdin <= sh_q[FRAME_BITS-1];
          end else if (tick) begin
            link.sclk <= 1'b0;
            bits_q    <= bits_q + 5'h1;
            sh_q      <= {sh_q[22:0], 1'b0};
            if (bits_q == LAST_BIT_CNT - 5'h1) begin
              st_q <= HS_GAP;
            end
          end
        end
        HS_GAP: begin
          // Raise select one tick after the last fall; it stays high at least one cycle, over the gap minimum
          if (tick) begin
            link.frame_sel_n <= 1'b1;
            busy_q           <= 1'b0;
            st_q             <= HS_IDLE;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // Slave always ready, OKAY
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// ==== tb/ddc_link_checker.sv ====
// Assertions on the host-to-converter link wires and frame completion.
// Assumes both ends share sys_clk and nrst; the bench instantiates it once.
`timescale 1ns/1ps
module ddc_link_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Link wires
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdin,
  // Converter completion pulse
  input wire logic frame_done_q
);
  logic [4:0] fall_cnt_q;
  logic [4:0] fall_cnt_d;
  logic       sclk_q;
  logic       sel_q;
  logic       full_q;
  logic       full_d;
  wire        sclk_fall = sclk_q & ~sclk & ~frame_sel_n;
  //////////////////////////////////////////////////
  // Falls per frame; select high clears, so a stray edge never carries over
  assign fall_cnt_d = frame_sel_n ? 5'h00 : fall_cnt_q + {4'h0, sclk_fall};
  assign full_d     = (sel_q & ~frame_sel_n) ? 1'b0 : (full_q | (fall_cnt_q == 5'h18));
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fall_cnt_q <= 5'h00;
      sclk_q     <= 1'b0;
      sel_q      <= 1'b1;
      full_q     <= 1'b0;
    end else begin
      fall_cnt_q <= fall_cnt_d;
      sclk_q     <= sclk;
      sel_q      <= frame_sel_n;
      full_q     <= full_d;
    end
  end
  //////////////////////////////////////////////////
  // One domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  idle_sclk_a: assert property (frame_sel_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  whole_frame_a: assert property ($rose(frame_sel_n) |-> fall_cnt_q == 5'h18)
    else $error("select raised before the last bit");
  sclk_pulse_a: assert property ($rose(sclk) |-> ##[1:4] $fell(sclk))
    else $error("serial clock high too long");
  data_hold_a: assert property ((sclk && $past(sclk)) |-> $stable(sdin))
    else $error("data changed while clock high");
  fall_hold_a: assert property ($fell(sclk) |-> $stable(sdin))
    else $error("data moved at the sampling clock fall");
  sel_gap_a: assert property ($rose(frame_sel_n) |=> frame_sel_n)
    else $error("select high gap too short");
  exec_time_a: assert property ((sclk_fall && fall_cnt_q == 5'h17) |-> ##[1:8] frame_done_q)
    else $error("frame not executed after last bit");
  done_full_a: assert property (frame_done_q |-> full_q)
    else $error("frame executed without all bits");
  done_pulse_a: assert property (frame_done_q |=> !frame_done_q)
    else $error("completion pulse too long");
  max_count_a: assert property (fall_cnt_q <= 5'h18)
    else $error("too many clock edges in a frame");
endmodule

// ==== tb/dual_dac_serial_command_port_test.sv ====
// Bench: host and converter joined by the link, plus a converter fed by the bench.
// Assumes package and interface compiled first; AHB master lives in tasks here.
`timescale 1ns/1ps
module dual_dac_serial_command_port_test;
  import ddc_pkg::*;
  typedef struct packed {
    logic [23:0] w;
    logic        s;
    logic [15:0] a;
    logic [15:0] b;
    logic [1:0]  pa;
    logic [1:0]  pb;
  } ddc_row_t;
  // Word, strobe, then expected codes and power modes
  localparam ddc_row_t ROWS [18] = '{
    '{24'h181234, 1'b1, 16'h1234, 16'h0000, 2'h0, 2'h0}, '{24'h015678, 1'b1, 16'h1234, 16'h0000, 2'h0, 2'h0},
    '{24'h090000, 1'b1, 16'h1234, 16'h5678, 2'h0, 2'h0}, '{24'h109abc, 1'b1, 16'h9abc, 16'h5678, 2'h0, 2'h0},
    '{24'h1f0f0f, 1'b1, 16'h0f0f, 16'h0f0f, 2'h0, 2'h0}, '{24'h3fffff, 1'b1, 16'h0f0f, 16'h0f0f, 2'h0, 2'h0},
    '{24'h1affff, 1'b1, 16'h0f0f, 16'h0f0f, 2'h0, 2'h0}, '{24'h300001, 1'b1, 16'h0f0f, 16'h0f0f, 2'h0, 2'h0},
    '{24'h001111, 1'b1, 16'h1111, 16'h0f0f, 2'h0, 2'h0}, '{24'h012222, 1'b1, 16'h1111, 16'h0f0f, 2'h0, 2'h0},
    '{24'h200031, 1'b1, 16'h1111, 16'h0f0f, 2'h3, 2'h0}, '{24'h183333, 1'b1, 16'h1111, 16'h0f0f, 2'h3, 2'h0},
    '{24'h200001, 1'b0, 16'h3333, 16'h2222, 2'h0, 2'h0}, '{24'h200012, 1'b1, 16'h3333, 16'h2222, 2'h0, 2'h1},
    '{24'h200022, 1'b1, 16'h3333, 16'h2222, 2'h0, 2'h2}, '{24'h280000, 1'b1, 16'h0000, 16'h0000, 2'h0, 2'h2},
    '{24'h280001, 1'b1, 16'h0000, 16'h0000, 2'h0, 2'h0}, '{24'h004444, 1'b1, 16'h0000, 16'h0000, 2'h0, 2'h0}};
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        strobe_n = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [15:0] dac_a_q;
  logic [15:0] dac_b_q;
  logic [15:0] dac_a2_q;
  logic [1:0]  pd_a_q;
  logic [1:0]  pd_b_q;
  logic [1:0]  pend_q;
  logic        done_q;
  logic [31:0] rd;
  int          n_fail = 0;
  int          n_compared = 0;
  ddc_link_if link ();
  ddc_link_if link_b ();
  //////////////////////////////////////////////////
  // Ends under test, checker on the shared link
  ddc_host i_ddc_host (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .link(link));
  ddc_device i_ddc_device (.sys_clk(sys_clk), .nrst(nrst), .link(link), .load_strobe_n(strobe_n),
    .dac_a_q(dac_a_q), .dac_b_q(dac_b_q), .pd_a_q(pd_a_q), .pd_b_q(pd_b_q), .pwrup_pend_q(pend_q),
    .frame_done_q(done_q));
  ddc_device #(.MIDSCALE(1'b1)) i_ddc_device_b (.sys_clk(sys_clk), .nrst(nrst), .link(link_b),
    .load_strobe_n(strobe_n),
    .dac_a_q(dac_a2_q), .dac_b_q(), .pd_a_q(), .pd_b_q(), .pwrup_pend_q(), .frame_done_q());
  ddc_link_checker i_ddc_link_checker (.sys_clk(sys_clk), .nrst(nrst), .frame_sel_n(link.frame_sel_n),
    .sclk(link.sclk), .sdin(link.sdin), .frame_done_q(done_q));
  always #20 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for hready; an exhausted bound ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n == 50) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  // Host frame: load word, start, wait for execution, then for idle
  task automatic send(input logic [23:0] w);
    int n;
    ahb(1'b1, 32'(ADDR_DATA), {8'h00, w});
    ahb(1'b1, 32'(ADDR_CTRL), 32'h1);
    for (n = 0; n < 3000 && done_q !== 1'b1; n++) @(negedge sys_clk);
    if (n == 3000) begin
      n_fail++;
      give_verdict();
    end
    @(posedge sys_clk);
    for (n = 0; n < 50; n++) begin
      ahb(1'b0, 32'(ADDR_STAT), 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 50) begin
      n_fail++;
      give_verdict();
    end
  endtask
  // Bench-made frame at 320 ns per bit; released data shows the inverse
  task automatic bang(input logic [23:0] w, input int nb);
    for (int k = 23; k > 23 - nb; k--) begin
      link_b.sdin <= w[k];
      link_b.sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      link_b.sclk <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    link_b.sdin <= ~link_b.sdin;
    @(posedge sys_clk);
  endtask
  //////////////////////////////////////////////////
  initial begin
    link_b.frame_sel_n <= 1'b1;
    link_b.sclk        <= 1'b0;
    link_b.sdin        <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check(32'(dac_a_q), 32'(ZERO_CODE));
    check({30'h0, link.sclk, link.frame_sel_n}, 32'h1);
    ahb(1'b0, 32'h10, 32'h0);
    check(rd, UNMAPPED_RD);
    check(32'(dac_a2_q), 32'(MID_CODE));
    for (int i = 0; i < 18; i++) begin
      strobe_n <= ROWS[i].s;
      @(posedge sys_clk);
      send(ROWS[i].w);
      check(32'(dac_a_q), 32'(ROWS[i].a));
      check(32'(dac_b_q), 32'(ROWS[i].b));
      check(32'({pd_b_q, pd_a_q}), 32'({ROWS[i].pb, ROWS[i].pa}));
      if (i == 12) begin
        check(32'(pend_q[0]), 32'h1);
        repeat (PWRUP_CYC) @(posedge sys_clk);
        check(32'(pend_q), 32'h0);
      end
    end
    // Aborted frame, then a full one with trailing edges, then a reframe
    link_b.frame_sel_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bang(24'h18abcd, 23);
    link_b.frame_sel_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(32'(dac_a2_q), 32'(MID_CODE));
    link_b.frame_sel_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bang(24'h18abcd, 24);
    bang(24'h185555, 24);
    repeat (8) @(posedge sys_clk);
    check(32'(dac_a2_q), 32'habcd);
    link_b.frame_sel_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    link_b.frame_sel_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bang(24'h185555, 24);
    repeat (8) @(posedge sys_clk);
    check(32'(dac_a2_q), 32'h5555);
    // Mid-run reset: code clears while held, midscale shows again after release
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(32'(dac_a2_q), 32'(ZERO_CODE));
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(32'(dac_a2_q), 32'(MID_CODE));
    give_verdict();
  end
endmodule
